// ===== design/systk_timer.sv
`timescale 1ns/1ps
`include "systk_cfg.svh"

module systk_timer (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // external reference clock pin
   input wire logic tickRefClk,
   // tick exception pend and summary interrupt
   output logic tickPend,
   output logic irq
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      systk_pkg::systk_bus_t bus;
      logic [31:0] rdData;
      systk_pkg::systk_ctrl_t ctrl;
      logic reachedZeroFlag;
      logic [`SYSTK_CNT_W-1:0] reload;
      logic [`SYSTK_CNT_W-1:0] current;
      logic pend;
      logic [`SYSTK_IRQ_W-1:0] irqStat;
      logic [`SYSTK_IRQ_W-1:0] irqMask;
      logic irqOut;
   } systk_state_t;

   systk_state_t state_q;
   systk_state_t state_d;
   systk_pkg::systk_wb_req_t req;
   logic refTick;

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                  sel: wb_sel_i, dat: wb_dat_i};

   systk_ref_sync u_ref_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .refClkPin(tickRefClk),
      .refTick(refTick)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
      hit = (adr == off);
   endfunction

   // byte-lane merge of write data into a 32-bit old value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   logic access;
   logic rdCsr;
   logic wrCsr;
   logic wrRvr;
   logic wrCvr;
   logic rdIst;
   logic wrImsk;
   logic step;
   logic zeroHit;
   logic [31:0] csrView;
   logic [31:0] wv;
   logic [`SYSTK_IRQ_W-1:0] ev;

   always_comb begin
      state_d = state_q;
      access = req.cyc & req.stb & (state_q.bus == systk_pkg::SYSTK_BUS_IDLE);
      rdCsr = access & ~req.we & hit(req.adr, `SYSTK_OFF_CSR);
      wrCsr = access & req.we & hit(req.adr, `SYSTK_OFF_CSR);
      wrRvr = access & req.we & hit(req.adr, `SYSTK_OFF_RVR);
      wrCvr = access & req.we & hit(req.adr, `SYSTK_OFF_CVR);
      rdIst = access & ~req.we & hit(req.adr, `SYSTK_OFF_IST);
      wrImsk = access & req.we & hit(req.adr, `SYSTK_OFF_IMSK);
      wv = 32'h00000000;
      ev = `SYSTK_IRQ_RST;

      csrView = 32'h00000000;
      csrView[`SYSTK_BIT_FLAG] = state_q.reachedZeroFlag;
      csrView[`SYSTK_BIT_CLKSEL] = state_q.ctrl.clkSel;
      csrView[`SYSTK_BIT_TICK_EXCEPTION_ENABLE] = state_q.ctrl.tickExcEn;
      csrView[`SYSTK_BIT_EN] = state_q.ctrl.enable;

      // counter tick source: core clock every cycle, else reference edge
      step = state_q.ctrl.enable & (state_q.ctrl.clkSel | refTick);
      zeroHit = 1'b0;

      // ---------- bus ----------
      state_d.bus = systk_pkg::SYSTK_BUS_IDLE;
      if (access) begin
         state_d.bus = systk_pkg::SYSTK_BUS_ACK;
         case (req.adr)
            `SYSTK_OFF_CSR: state_d.rdData = csrView;
            `SYSTK_OFF_RVR: state_d.rdData = {8'h00, state_q.reload};
            `SYSTK_OFF_CVR: state_d.rdData = {8'h00, state_q.current};
            `SYSTK_OFF_IST: state_d.rdData = {30'h0, state_q.irqStat};
            `SYSTK_OFF_IMSK: state_d.rdData = {30'h0, state_q.irqMask};
            default: state_d.rdData = `SYSTK_UNMAPPED;
         endcase
      end

      if (wrCsr) begin
         wv = merge(csrView, req.dat, req.sel);
         state_d.ctrl.clkSel = wv[`SYSTK_BIT_CLKSEL];
         state_d.ctrl.tickExcEn = wv[`SYSTK_BIT_TICK_EXCEPTION_ENABLE];
         state_d.ctrl.enable = wv[`SYSTK_BIT_EN];
      end
      if (wrRvr) begin
         wv = merge({8'h00, state_q.reload}, req.dat, req.sel);
         state_d.reload = wv[`SYSTK_CNT_W-1:0];
      end
      if (wrImsk) begin
         wv = merge({30'h0, state_q.irqMask}, req.dat, req.sel);
         state_d.irqMask = wv[`SYSTK_IRQ_W-1:0];
      end

      // ---------- counter ----------
      if (wrCvr) begin
         // write clears, data ignored, and no exception is pended
         state_d.current = `SYSTK_CNT_RST;
      end else if (step) begin
         if (state_q.current == `SYSTK_CNT_RST) begin
            // reload; a zero reload just keeps the counter at zero
            state_d.current = state_q.reload;
         end else begin
            state_d.current = state_q.current - 24'h000001;
            zeroHit = (state_q.current == 24'h000001);
         end
      end

      // ---------- flag: read/cvr-write clear, set wins ----------
      if (rdCsr | wrCvr) begin
         state_d.reachedZeroFlag = 1'b0;
      end
      if (zeroHit) begin
         state_d.reachedZeroFlag = 1'b1;
      end

      // exception pend pulse on count to zero only
      state_d.pend = zeroHit & state_q.ctrl.tickExcEn;

      // ---------- interrupt status ----------
      ev[`SYSTK_IRQ_ZERO] = zeroHit;
      ev[`SYSTK_IRQ_CVRWR] = wrCvr;
      if (rdIst) begin
         state_d.irqStat = `SYSTK_IRQ_RST;
      end
      state_d.irqStat = state_d.irqStat | ev;
      state_d.irqOut = |(state_d.irqStat & state_d.irqMask);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q.bus <= systk_pkg::SYSTK_BUS_IDLE;
         state_q.rdData <= 32'h00000000;
         state_q.ctrl <= `SYSTK_CSR_RST;
         state_q.reachedZeroFlag <= 1'b0;
         state_q.reload <= `SYSTK_CNT_RST;
         state_q.current <= `SYSTK_CNT_RST;
         state_q.pend <= 1'b0;
         state_q.irqStat <= `SYSTK_IRQ_RST;
         state_q.irqMask <= `SYSTK_IRQ_RST;
         state_q.irqOut <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign wb_ack_o = (state_q.bus == systk_pkg::SYSTK_BUS_ACK);
   assign wb_dat_o = state_q.rdData;
   assign tickPend = state_q.pend;
   assign irq = state_q.irqOut;

endmodule

// ===== design/systk_cfg.svh
`ifndef SYSTK_CFG_SVH
`define SYSTK_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SYSTK_OFF_CSR 8'h10
`define SYSTK_OFF_RVR 8'h14
`define SYSTK_OFF_CVR 8'h18
`define SYSTK_OFF_IST 8'h1c
`define SYSTK_OFF_IMSK 8'h20

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define SYSTK_CNT_W 24
`define SYSTK_BIT_EN 0
`define SYSTK_BIT_TICK_EXCEPTION_ENABLE 1
`define SYSTK_BIT_CLKSEL 2
`define SYSTK_BIT_FLAG 16
`define SYSTK_IRQ_W 2
`define SYSTK_IRQ_ZERO 0
`define SYSTK_IRQ_CVRWR 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define SYSTK_CSR_RST 3'h0
`define SYSTK_CNT_RST 24'h000000
`define SYSTK_IRQ_RST 2'h0
`define SYSTK_UNMAPPED 32'h00000000

`endif

// ===== design/systk_pkg.sv
`include "systk_cfg.svh"

package systk_pkg;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } systk_wb_req_t;

   typedef struct packed {
      logic clkSel;
      logic tickExcEn;
      logic enable;
   } systk_ctrl_t;

   typedef enum logic [1:0] {
      SYSTK_BUS_IDLE = 2'b00,
      SYSTK_BUS_ACK = 2'b01
   } systk_bus_t;

   typedef struct packed {
      logic [2:0] refSync;
      logic refEdge;
   } systk_ref_t;

endpackage

// ===== design/systk_ref_sync.sv
`timescale 1ns/1ps
`include "systk_cfg.svh"

// two-stage synchroniser on the external reference clock, with a rising edge pulse
module systk_ref_sync (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // reference pin
   input wire logic refClkPin,
   // one-cycle pulse per reference rising edge
   output logic refTick
);

   systk_pkg::systk_ref_t state_q;
   systk_pkg::systk_ref_t state_d;

   always_comb begin
      state_d = state_q;
      state_d.refSync = {state_q.refSync[1:0], refClkPin};
      // first stage feeds only the second; edge is seen between stages 2 and 3
      state_d.refEdge = state_q.refSync[1] & ~state_q.refSync[2];
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign refTick = state_q.refEdge;

endmodule

// ===== test/systk_timer_checker.sv
`timescale 1ns/1ps
module systk_timer_checker (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // events
   input wire logic tickPend,
   input wire logic irq
);
   // ------
   // checks
   // ------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire rd = wb_ack_o && !wb_we_i;
   property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
   property p_rvr_hi; rd && wb_adr_i == 8'h14 |-> wb_dat_o[31:24] == 8'h00; endproperty
   a_rvr_hi: assert property (p_rvr_hi) else $error("reload top set");
   property p_cvr_hi; rd && wb_adr_i == 8'h18 |-> wb_dat_o[31:24] == 8'h00; endproperty
   a_cvr_hi: assert property (p_cvr_hi) else $error("current top set");
   property p_csr_rsv;
      rd && wb_adr_i == 8'h10 |-> wb_dat_o[31:17] == 15'h0 && wb_dat_o[15:3] == 13'h0;
   endproperty
   a_csr_rsv: assert property (p_csr_rsv) else $error("control spare set");
   property p_unmap; rd && wb_adr_i == 8'h04 |-> wb_dat_o == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("hole reads data");
   property p_pend_pulse; tickPend |=> !tickPend; endproperty
   a_pend_pulse: assert property (p_pend_pulse) else $error("pend too long");
   property p_cvr_nopend;
      wb_ack_o && wb_we_i && wb_adr_i == 8'h18 |-> !tickPend;
   endproperty
   a_cvr_nopend: assert property (p_cvr_nopend) else $error("pend on clear");
   c_wr: cover property (wb_ack_o && wb_we_i);
   c_pend: cover property (tickPend);
   c_irq: cover property ($rose(irq));
endmodule
bind systk_timer systk_timer_checker i_chk (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .tickPend, .irq);

// ===== test/test_systk_timer.sv
`timescale 1ns/1ps
module test_systk_timer;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic refClk = 1'b0;
   systk_pkg::systk_wb_req_t rq = '0;
   logic [31:0] rdat, q;
   logic ack, pend, irq;
   logic [15:0] rv = 16'h004c;
   int errTotal = 0;
   int nChecks = 0;
   int refDiv = 0;
   int g, n;
   always #4 clk = ~clk;
   // reference pin period is ten core cycles
   always @(posedge clk) begin
      refDiv <= (refDiv == 4) ? 0 : refDiv + 1;
      if (refDiv == 4)
         refClk <= ~refClk;
   end
   systk_timer i_systk_timer (.clk, .sys_rst, .wb_cyc_i(rq.cyc), .wb_stb_i(rq.stb),
      .wb_we_i(rq.we), .wb_adr_i(rq.adr), .wb_sel_i(rq.sel), .wb_dat_i(rq.dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .tickRefClk(refClk), .tickPend(pend), .irq(irq));
   // -------
   // helpers
   // -------
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      nChecks++;
      if (s !== e) begin
         errTotal++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      rq <= '{1'b1, 1'b1, w, a, 4'hf, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      rq <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, q, e);
   endtask
   // cycles from one pend pulse to the next
   task automatic gap(output int c);
      int k;
      k = 0;
      while (pend !== 1'b1 && k < 999) begin
         @(posedge clk);
         k++;
      end
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (pend !== 1'b1 && c < 999);
   endtask
   task automatic cnt(input int m, output int c);
      c = 0;
      repeat (m) begin
         @(posedge clk);
         if (pend === 1'b1)
            c++;
      end
   endtask
   task automatic giveVerdict;
      $display("checks %0d mismatches %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // -----
   // tests
   // -----
   initial begin
      #200000;
      errTotal++;
      giveVerdict;
   end
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h10, 32'h0, "csr");
      rd(8'h14, 32'h0, "rvr");
      rd(8'h04, 32'h0, "hole");
      rv = lfsr(rv);
      bus(1'b1, 8'h14, {rv, rv});
      rd(8'h14, {8'h00, rv[7:0], rv}, "rvr rand");
      $display("end regs");
      bus(1'b1, 8'h14, 32'h5);
      bus(1'b1, 8'h18, {rv, rv});
      rd(8'h18, 32'h0, "cvr clr");
      bus(1'b1, 8'h20, 32'h1);
      bus(1'b1, 8'h10, 32'h7);
      gap(g);
      chk("core gap", g, 32'h6);
      chk("irq", irq, 1'b1);
      bus(1'b1, 8'h10, 32'h6);
      rd(8'h10, 32'h10006, "flag set");
      rd(8'h10, 32'h6, "flag rd clr");
      rd(8'h1c, 32'h3, "status");
      rd(8'h1c, 32'h0, "status clr");
      chk("irq clr", irq, 1'b0);
      bus(1'b0, 8'h18, 32'h0);
      chk("stopped", q, 32'h3);
      repeat (10) @(posedge clk);
      rd(8'h18, 32'h3, "hold");
      $display("end core");
      bus(1'b1, 8'h14, 32'h28);
      bus(1'b1, 8'h10, 32'h7);
      gap(g);
      chk("long gap", g, 32'h29);
      repeat (10) @(posedge clk);
      rv = lfsr(rv);
      bus(1'b1, 8'h18, {rv, rv});
      cnt(30, n);
      chk("pend on clr", n, 32'h0);
      rd(8'h10, 32'h7, "flag wr clr");
      rd(8'h1c, 32'h3, "status 2");
      // stop first: the running count would otherwise reach zero mid-sequence
      bus(1'b1, 8'h10, 32'h6);
      bus(1'b1, 8'h14, 32'h0);
      bus(1'b1, 8'h18, 32'h0);
      bus(1'b1, 8'h10, 32'h7);
      cnt(20, n);
      chk("zero rvr", n, 32'h0);
      rd(8'h18, 32'h0, "zero hold");
      chk("irq masked", irq, 1'b0);
      $display("end clear");
      bus(1'b1, 8'h14, 32'h5);
      bus(1'b1, 8'h10, 32'h5);
      cnt(20, n);
      chk("no tick_exception_enable", n, 32'h0);
      rd(8'h10, 32'h10005, "flag no int");
      bus(1'b1, 8'h14, 32'h3);
      bus(1'b1, 8'h10, 32'h3);
      gap(g);
      chk("ref gap", g, 32'h28);
      $display("end ref");
      giveVerdict;
   end
endmodule
